// [dpssm_defs.svh]
// constants for the fieldbus slave protocol state machine
`ifndef DPSSM_DEFS_SVH
`define DPSSM_DEFS_SVH
`define DPSSM_TEL_SET_ADDR 3'h0
`define DPSSM_TEL_PRM 3'h1
`define DPSSM_TEL_CFG 3'h2
`define DPSSM_TEL_DIAG 3'h3
`define DPSSM_TEL_GET_CFG 3'h4
`define DPSSM_TEL_DATA 3'h5
`define DPSSM_TEL_RD_IN 3'h6
`define DPSSM_TEL_RD_OUT 3'h7
`define DPSSM_CFG_OK 2'h0
`define DPSSM_CFG_BAD 2'h1
`define DPSSM_CFG_ADAPT 2'h2
`define DPSSM_DIAG_STD_LEN 4'h6
`define DPSSM_WD_RESET 16'h0000
`define DPSSM_DIAG_ST_BIT 3
`define DPSSM_LEN_RESET 8'h00
`endif

// [dpssm_pkg.sv]
// types for the fieldbus slave protocol state machine
package dpssm_pkg;
  typedef enum logic [1:0] {
    dpssm_power_on,
    dpssm_wait_prm,
    dpssm_wait_cfg,
    dpssm_data_exch
  } dpssm_state_t;
  typedef enum logic [1:0] {
    dpssm_ans_none,
    dpssm_ans_ack,
    dpssm_ans_reject,
    dpssm_ans_data
  } dpssm_ans_t;
endpackage

// [dpssm_watchdog.sv]
// bus watchdog: loadable down counter with timeout pulse
`timescale 1ns/1ps
`include "dpssm_defs.svh"
module dpssm_watchdog (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic retrigger,
  input wire logic stop,
  input wire logic tick,
  // status
  output logic running,
  output logic expired
);
  logic [15:0] reload;
  logic [15:0] count;
  wire at_end = running && tick && (count == 16'h0001);
  wire zero_load = (load_value == 16'h0000);

  always_ff @(posedge clock)
  begin
    if (reset || stop)
    begin
      running <= 1'b0;
      count <= `DPSSM_WD_RESET;
      reload <= `DPSSM_WD_RESET;
      expired <= 1'b0;
    end
    else
    begin
      expired <= at_end;
      if (load)
      begin
        // zero value means watchdog switched off
        reload <= load_value;
        count <= load_value;
        running <= !zero_load;
      end
      else if (at_end)
      begin
        running <= 1'b0;
        count <= `DPSSM_WD_RESET;
      end
      else if (retrigger && running)
        count <= reload;
      else if (running && tick)
        count <= count - 16'h0001;
    end
  end
endmodule

// [dpssm_core.sv]
// protocol state machine of a fieldbus slave
`timescale 1ns/1ps
`include "dpssm_defs.svh"
module dpssm_core (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // decoded telegram from the receiver
  input wire logic tel_valid,
  input wire logic [2:0] tel_kind,
  input wire logic tel_ok,
  input wire logic tel_from_owner,
  input wire logic [15:0] tel_wd_value,
  input wire logic [7:0] tel_in_len,
  input wire logic [7:0] tel_out_len,
  input wire logic wd_tick,
  // answer to the receiver side
  output logic ans_valid,
  output dpssm_pkg::dpssm_ans_t ans_kind,
  output logic [3:0] ans_std_len,
  output logic [1:0] ans_state,
  output logic ans_autonomous,
  // application handshake
  output logic app_prm_req,
  input wire logic app_prm_done,
  input wire logic app_prm_accept,
  output logic app_cfg_req,
  output logic [7:0] app_cfg_in_len,
  output logic [7:0] app_cfg_out_len,
  input wire logic app_cfg_done,
  input wire logic [1:0] app_cfg_result,
  input wire logic [7:0] app_adapt_in_len,
  input wire logic [7:0] app_adapt_out_len,
  // status
  output dpssm_pkg::dpssm_state_t state,
  output logic addr_set,
  output logic [7:0] io_in_len,
  output logic [7:0] io_out_len,
  output logic data_exchange,
  output logic wd_running,
  output logic wd_expired
);
  dpssm_pkg::dpssm_state_t next_state;
  logic prm_ok;
  logic [15:0] prm_wd;

  function automatic logic is_kind(input logic [2:0] k, input logic [2:0] want);
    is_kind = (k == want);
  endfunction

  wire tel = tel_valid && tel_ok;
  wire t_addr = tel && is_kind(tel_kind, `DPSSM_TEL_SET_ADDR);
  wire t_prm = tel && is_kind(tel_kind, `DPSSM_TEL_PRM);
  wire t_cfg = tel && is_kind(tel_kind, `DPSSM_TEL_CFG);
  wire t_diag = tel && is_kind(tel_kind, `DPSSM_TEL_DIAG);
  wire t_gcfg = tel && is_kind(tel_kind, `DPSSM_TEL_GET_CFG);
  wire t_data = tel && is_kind(tel_kind, `DPSSM_TEL_DATA);
  wire t_rio = tel && (is_kind(tel_kind, `DPSSM_TEL_RD_IN) ||
                       is_kind(tel_kind, `DPSSM_TEL_RD_OUT));
  wire in_po = (state == dpssm_pkg::dpssm_power_on);
  wire in_prm = (state == dpssm_pkg::dpssm_wait_prm);
  wire in_cfg = (state == dpssm_pkg::dpssm_wait_cfg);
  wire in_dx = (state == dpssm_pkg::dpssm_data_exch);
  wire busy = app_prm_req || app_cfg_req;
  // application still deciding: new parameter or config telegrams are refused
  wire take_prm = t_prm && !busy && !in_po;
  wire take_cfg = t_cfg && !busy && in_cfg && prm_ok;
  wire cfg_good = app_cfg_done && app_cfg_req &&
                  (app_cfg_result == `DPSSM_CFG_OK || app_cfg_result == `DPSSM_CFG_ADAPT);
  wire cfg_adapt = app_cfg_result == `DPSSM_CFG_ADAPT;
  wire prm_good = app_prm_done && app_prm_req && app_prm_accept;
  wire prm_bad = app_prm_done && app_prm_req && !app_prm_accept;
  wire cfg_bad = app_cfg_done && app_cfg_req && !cfg_good;
  wire wd_stop = reset || prm_bad || (wd_expired && !in_po);
  wire wd_retrig = tel && tel_from_owner && in_dx;

  dpssm_watchdog u_wd (
    .clock(clock),
    .reset(reset),
    .load(prm_good),
    .load_value(prm_wd),
    .retrigger(wd_retrig),
    .stop(prm_bad),
    .tick(wd_tick),
    .running(wd_running),
    .expired(wd_expired)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      dpssm_pkg::dpssm_power_on:
        if (t_addr || t_prm)
          next_state = dpssm_pkg::dpssm_wait_prm;
      dpssm_pkg::dpssm_wait_prm:
        if (prm_good)
          next_state = dpssm_pkg::dpssm_wait_cfg;
      dpssm_pkg::dpssm_wait_cfg:
        if (prm_bad || cfg_bad)
          next_state = dpssm_pkg::dpssm_wait_prm;
        else if (cfg_good)
          next_state = dpssm_pkg::dpssm_data_exch;
      dpssm_pkg::dpssm_data_exch:
        if (prm_bad || cfg_bad)
          next_state = dpssm_pkg::dpssm_wait_prm;
        else if (take_prm)
          next_state = dpssm_pkg::dpssm_wait_prm;
        else if (take_cfg)
          next_state = dpssm_pkg::dpssm_wait_cfg;
      default:
        next_state = dpssm_pkg::dpssm_power_on;
    endcase
    if (wd_expired && !in_po)
      next_state = dpssm_pkg::dpssm_wait_prm;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state <= dpssm_pkg::dpssm_power_on;
    else
      state <= next_state;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      addr_set <= 1'b0;
    else if (t_addr && in_po)
      addr_set <= 1'b1;
  end

  // parameter path: user bytes travel alongside; we only hold the request
  always_ff @(posedge clock)
  begin
    if (reset || wd_stop)
    begin
      app_prm_req <= 1'b0;
      prm_ok <= 1'b0;
      prm_wd <= `DPSSM_WD_RESET;
    end
    else if (take_prm || (t_prm && in_po))
    begin
      app_prm_req <= 1'b1;
      prm_ok <= 1'b0;
      prm_wd <= tel_wd_value;
    end
    else if (app_prm_done && app_prm_req)
    begin
      app_prm_req <= 1'b0;
      prm_ok <= app_prm_accept;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset || wd_stop)
    begin
      app_cfg_req <= 1'b0;
      app_cfg_in_len <= `DPSSM_LEN_RESET;
      app_cfg_out_len <= `DPSSM_LEN_RESET;
      io_in_len <= `DPSSM_LEN_RESET;
      io_out_len <= `DPSSM_LEN_RESET;
    end
    else if (take_cfg)
    begin
      app_cfg_req <= 1'b1;
      app_cfg_in_len <= tel_in_len;
      app_cfg_out_len <= tel_out_len;
    end
    else if (app_cfg_done && app_cfg_req)
    begin
      app_cfg_req <= 1'b0;
      if (cfg_good)
      begin
        io_in_len <= cfg_adapt ? app_adapt_in_len : app_cfg_in_len;
        io_out_len <= cfg_adapt ? app_adapt_out_len : app_cfg_out_len;
      end
    end
  end

  // answer decision, registered one cycle after the telegram
  wire [1:0] next_ans =
    t_diag ? dpssm_pkg::dpssm_ans_data :
    t_gcfg ? dpssm_pkg::dpssm_ans_data :
    t_addr ? (in_po ? dpssm_pkg::dpssm_ans_ack : dpssm_pkg::dpssm_ans_none) :
    (in_prm && !t_prm) ? dpssm_pkg::dpssm_ans_reject :
    t_prm ? (take_prm || in_po ? dpssm_pkg::dpssm_ans_ack : dpssm_pkg::dpssm_ans_reject) :
    t_cfg ? (take_cfg ? dpssm_pkg::dpssm_ans_ack : dpssm_pkg::dpssm_ans_reject) :
    (t_data || t_rio) ? (in_dx ? dpssm_pkg::dpssm_ans_data :
                         dpssm_pkg::dpssm_ans_reject) :
    dpssm_pkg::dpssm_ans_none;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ans_valid <= 1'b0;
      ans_kind <= dpssm_pkg::dpssm_ans_none;
      ans_std_len <= 4'h0;
      ans_state <= 2'h0;
      ans_autonomous <= 1'b0;
    end
    else
    begin
      ans_valid <= tel && (next_ans != dpssm_pkg::dpssm_ans_none);
      ans_kind <= tel ? dpssm_pkg::dpssm_ans_t'(next_ans) : dpssm_pkg::dpssm_ans_none;
      ans_std_len <= t_diag ? `DPSSM_DIAG_STD_LEN : 4'h0;
      ans_state <= state;
      ans_autonomous <= t_rio && in_dx;
    end
  end

  assign data_exchange = in_dx;

  chk_addr_only_po: assert property (@(posedge clock) disable iff (reset)
    t_addr && !in_po |=> !(ans_valid && ans_kind == dpssm_pkg::dpssm_ans_ack))
    else $error("set-address acknowledged outside power-on");
  chk_prm_reject: assert property (@(posedge clock) disable iff (reset)
    in_prm && tel && !t_prm && !t_addr && !t_diag && !t_gcfg |=>
    ans_kind == dpssm_pkg::dpssm_ans_reject)
    else $error("non-parameter telegram not rejected in wait-prm");
  chk_no_data_prm: assert property (@(posedge clock) disable iff (reset)
    in_prm && t_data |=> ans_kind != dpssm_pkg::dpssm_ans_data)
    else $error("data exchanged in wait-prm");
  chk_dx_entry: assert property (@(posedge clock) disable iff (reset)
    !in_dx ##1 in_dx |-> $past(cfg_good) && prm_ok)
    else $error("data exchange entered without acceptance");
  chk_diag_len: assert property (@(posedge clock) disable iff (reset)
    t_diag |=> ans_valid && ans_std_len == 4'h6)
    else $error("diagnostic answer lacks six standard octets");
  chk_gcfg_any: assert property (@(posedge clock) disable iff (reset)
    t_gcfg |=> ans_valid && ans_kind == dpssm_pkg::dpssm_ans_data)
    else $error("configuration read not answered");
  chk_rio_auto: assert property (@(posedge clock) disable iff (reset)
    t_rio && in_dx |=> ans_autonomous && !$rose(app_cfg_req))
    else $error("read inputs or outputs not served autonomously");
  chk_wd_fall: assert property (@(posedge clock) disable iff (reset)
    wd_expired && !in_po |=> state == dpssm_pkg::dpssm_wait_prm)
    else $error("watchdog expiry did not return to wait-prm");
  chk_adapt_len: assert property (@(posedge clock) disable iff (reset)
    app_cfg_req && app_cfg_done && app_cfg_result == 2'h2 |=>
    io_in_len == $past(app_adapt_in_len))
    else $error("adaptable length not taken");

  cov_reach_dx: cover property (@(posedge clock) disable iff (reset) $rose(in_dx));
  cov_wd_timeout: cover property (@(posedge clock) disable iff (reset) wd_expired && in_dx);
  cov_cfg_adapt: cover property (@(posedge clock) disable iff (reset) cfg_good && cfg_adapt);
  cov_prm_reject: cover property (@(posedge clock) disable iff (reset) prm_bad);
endmodule

// [dpssm_master.sv]
// bus master model that hands decoded telegrams to the slave core
`timescale 1ns/1ps
module dpssm_master (
  // clock
  input wire logic clock,
  // telegram toward the slave
  output logic tel_valid,
  output logic [2:0] tel_kind,
  output logic tel_ok,
  output logic tel_from_owner,
  output logic [15:0] tel_wd_value,
  output logic [7:0] tel_in_len,
  output logic [7:0] tel_out_len
);
  initial
  begin
    tel_valid = 1'b0;
    tel_kind = 3'h0;
    tel_ok = 1'b0;
    tel_from_owner = 1'b0;
    tel_wd_value = 16'h0000;
    tel_in_len = 8'h00;
    tel_out_len = 8'h00;
  end
  // one telegram for one cycle; fields are inverted afterwards so stale values never help
  task automatic send(input logic [2:0] k, input logic own, input logic [15:0] wd,
                      input logic [7:0] il, input logic [7:0] ol);
    @(negedge clock);
    tel_valid = 1'b1;
    tel_kind = k;
    tel_ok = 1'b1;
    tel_from_owner = own;
    tel_wd_value = wd;
    tel_in_len = il;
    tel_out_len = ol;
    @(negedge clock);
    tel_valid = 1'b0;
    tel_kind = ~k;
    tel_ok = 1'b0;
    tel_from_owner = ~own;
    tel_wd_value = ~wd;
    tel_in_len = ~il;
    tel_out_len = ~ol;
  endtask
endmodule

// [dp_slave_state_machine_tb.sv]
// testbench for the fieldbus slave protocol state machine
`timescale 1ns/1ps
`include "dpssm_defs.svh"
module dp_slave_state_machine_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic tel_valid, tel_ok, tel_from_owner, wd_tick = 1'b0;
  logic [2:0] tel_kind;
  logic [15:0] tel_wd_value;
  logic [7:0] tel_in_len, tel_out_len, io_in_len, io_out_len, app_cfg_in_len, app_cfg_out_len;
  logic app_prm_done = 1'b0, app_prm_accept = 1'b0, app_cfg_done = 1'b0;
  logic [1:0] app_cfg_result = 2'h0;
  logic [7:0] app_adapt_in_len = 8'h00, app_adapt_out_len = 8'h00;
  logic ans_valid, ans_autonomous, app_prm_req, app_cfg_req, addr_set, data_exchange;
  logic wd_running, wd_expired;
  logic [3:0] ans_std_len;
  logic [1:0] ans_state;
  dpssm_pkg::dpssm_ans_t ans_kind;
  dpssm_pkg::dpssm_state_t state;
  int failures = 0;
  int cmp_count = 0;
  always #4 clock = ~clock;
  dpssm_master u_master (.clock(clock), .tel_valid(tel_valid), .tel_kind(tel_kind),
    .tel_ok(tel_ok), .tel_from_owner(tel_from_owner), .tel_wd_value(tel_wd_value),
    .tel_in_len(tel_in_len), .tel_out_len(tel_out_len));
  dpssm_core u_dut (.clock(clock), .reset(reset), .tel_valid(tel_valid), .tel_kind(tel_kind),
    .tel_ok(tel_ok), .tel_from_owner(tel_from_owner), .tel_wd_value(tel_wd_value),
    .tel_in_len(tel_in_len), .tel_out_len(tel_out_len), .wd_tick(wd_tick),
    .ans_valid(ans_valid), .ans_kind(ans_kind), .ans_std_len(ans_std_len),
    .ans_state(ans_state), .ans_autonomous(ans_autonomous), .app_prm_req(app_prm_req),
    .app_prm_done(app_prm_done), .app_prm_accept(app_prm_accept), .app_cfg_req(app_cfg_req),
    .app_cfg_in_len(app_cfg_in_len), .app_cfg_out_len(app_cfg_out_len),
    .app_cfg_done(app_cfg_done), .app_cfg_result(app_cfg_result),
    .app_adapt_in_len(app_adapt_in_len), .app_adapt_out_len(app_adapt_out_len),
    .state(state), .addr_set(addr_set), .io_in_len(io_in_len), .io_out_len(io_out_len),
    .data_exchange(data_exchange), .wd_running(wd_running), .wd_expired(wd_expired));
  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask
  // send returns at the negedge where the registered answer stands
  task automatic ans(input logic [2:0] k, input logic own, input logic v, input logic [1:0] ak);
    u_master.send(k, own, 16'h0004, 8'h04, 8'h03);
    check("ans_valid", 16'(v), 16'(ans_valid));
    if (v)
      check("ans_kind", 16'(ak), 16'(ans_kind));
  endtask
  task automatic st(input dpssm_pkg::dpssm_state_t e);
    repeat (2) @(negedge clock);
    check("state", 16'(e), 16'(state));
  endtask
  task automatic app_prm(input logic acc);
    for (int i = 0; i < 10 && app_prm_req !== 1'b1; i++) @(negedge clock);
    check("app_prm_req", 16'h0001, 16'(app_prm_req));
    app_prm_done = 1'b1;
    app_prm_accept = acc;
    @(negedge clock);
    app_prm_done = 1'b0;
  endtask
  task automatic app_cfg(input logic [1:0] r);
    for (int i = 0; i < 10 && app_cfg_req !== 1'b1; i++) @(negedge clock);
    check("app_cfg_req", 16'h0001, 16'(app_cfg_req));
    check("app_cfg_in_len", 16'h0004, 16'(app_cfg_in_len));
    check("app_cfg_out_len", 16'h0003, 16'(app_cfg_out_len));
    app_cfg_done = 1'b1;
    app_cfg_result = r;
    app_adapt_in_len = 8'h03;
    app_adapt_out_len = 8'h02;
    @(negedge clock);
    app_cfg_done = 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(negedge clock) wd_tick = 1'b1;
      @(negedge clock) wd_tick = 1'b0;
    end
  endtask
  task automatic t_reset;
    check("state", 16'(dpssm_pkg::dpssm_power_on), 16'(state));
    check("addr_set", 16'h0000, 16'(addr_set));
    check("wd_running", 16'h0000, 16'(wd_running));
    check("io_in_len", 16'h0000, 16'(io_in_len));
    $display("test reset done");
  endtask
  task automatic t_address;
    u_master.send(`DPSSM_TEL_SET_ADDR, 1'b1, 16'h0004, 8'h04, 8'h03);
    st(dpssm_pkg::dpssm_wait_prm);
    check("addr_set", 16'h0001, 16'(addr_set));
    ans(`DPSSM_TEL_SET_ADDR, 1'b1, 1'b0, 2'h0);
    $display("test address done");
  endtask
  task automatic t_wait_prm;
    logic [2:0] kinds [4] = '{`DPSSM_TEL_CFG, `DPSSM_TEL_DATA, `DPSSM_TEL_RD_IN, `DPSSM_TEL_RD_OUT};
    foreach (kinds[i]) ans(kinds[i], 1'b1, 1'b1, dpssm_pkg::dpssm_ans_reject);
    check("data_exchange", 16'h0000, 16'(data_exchange));
    u_master.send(`DPSSM_TEL_DIAG, 1'b0, 16'h0004, 8'h04, 8'h03);
    check("diag_valid", 16'h0001, 16'(ans_valid));
    check("ans_std_len", 16'(`DPSSM_DIAG_STD_LEN), 16'(ans_std_len));
    check("ans_state", 16'(dpssm_pkg::dpssm_wait_prm), 16'(ans_state));
    $display("test wait_prm done");
  endtask
  task automatic t_config;
    u_master.send(`DPSSM_TEL_PRM, 1'b1, 16'h0004, 8'h04, 8'h03);
    app_prm(1'b0);
    st(dpssm_pkg::dpssm_wait_prm);
    u_master.send(`DPSSM_TEL_PRM, 1'b1, 16'h0004, 8'h04, 8'h03);
    app_prm(1'b1);
    st(dpssm_pkg::dpssm_wait_cfg);
    check("wd_running", 16'h0001, 16'(wd_running));
    u_master.send(`DPSSM_TEL_CFG, 1'b1, 16'h0004, 8'h04, 8'h03);
    app_cfg(`DPSSM_CFG_BAD);
    st(dpssm_pkg::dpssm_wait_prm);
    u_master.send(`DPSSM_TEL_PRM, 1'b1, 16'h0004, 8'h04, 8'h03);
    app_prm(1'b1);
    u_master.send(`DPSSM_TEL_CFG, 1'b1, 16'h0004, 8'h04, 8'h03);
    app_cfg(`DPSSM_CFG_ADAPT);
    st(dpssm_pkg::dpssm_data_exch);
    check("io_in_len", 16'h0003, 16'(io_in_len));
    check("io_out_len", 16'h0002, 16'(io_out_len));
    $display("test config done");
  endtask
  task automatic t_reads;
    ans(`DPSSM_TEL_RD_IN, 1'b0, 1'b1, dpssm_pkg::dpssm_ans_data);
    check("ans_autonomous", 16'h0001, 16'(ans_autonomous));
    ans(`DPSSM_TEL_RD_OUT, 1'b0, 1'b1, dpssm_pkg::dpssm_ans_data);
    check("app_prm_req", 16'h0000, 16'(app_prm_req));
    u_master.send(`DPSSM_TEL_GET_CFG, 1'b0, 16'h0004, 8'h04, 8'h03);
    check("get_cfg_valid", 16'h0001, 16'(ans_valid));
    $display("test reads done");
  endtask
  task automatic t_watchdog;
    ticks(3);
    u_master.send(`DPSSM_TEL_DATA, 1'b1, 16'h0004, 8'h04, 8'h03);
    ticks(3);
    st(dpssm_pkg::dpssm_data_exch);
    ticks(1);
    check("wd_expired", 16'h0001, 16'(wd_expired));
    ticks(2);
    st(dpssm_pkg::dpssm_wait_prm);
    check("wd_running", 16'h0000, 16'(wd_running));
    $display("test watchdog done");
  endtask
  // reset in mid-run with the watchdog armed must drop everything back to power-on
  task automatic t_midreset;
    u_master.send(`DPSSM_TEL_PRM, 1'b1, 16'h0004, 8'h04, 8'h03);
    app_prm(1'b1);
    check("wd_running", 16'h0001, 16'(wd_running));
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    t_reset();
    check("app_prm_req", 16'h0000, 16'(app_prm_req));
    ans(`DPSSM_TEL_SET_ADDR, 1'b1, 1'b1, dpssm_pkg::dpssm_ans_ack);
    $display("test midreset done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_address();
    t_wait_prm();
    t_config();
    t_reads();
    t_watchdog();
    t_midreset();
    wrap_up();
  end
endmodule
